/* File: core/content_protect_status_irq.sv */
/*
 * Content-protection status flags, interrupt enable register and the
 * hold that stalls authentication at the key handshake points.
 * Assumes a serial-control decoder drives the register port, the cipher
 * engine gives one-cycle event pulses and the control register gives
 * one-cycle acknowledge pulses, all on the same clock.
 */
`timescale 1ns/1ps

// How it works
// - hot plug sets bit 4, read clears
// - bit 3 shows receiver detected now
// - key list loaded sets bit 2, holds
// - list acknowledge resumes and clears bit 2
// - receiver key loaded sets bit 1
// - non-repeater pauses until key acknowledge
// - key acknowledge clears bit 1
// - successful authentication sets bit 0
// - loss or restart clears bit 0
// - enable register resets zero; bit 7 indirect
// - enable bit 6: receiver detected interrupt
// - select bit delays detect until lock
// - enable bit 5 passes downstream interrupts
// - bit 4 list ready, bit 3 key
// - enable bit 2: authentication failure or loss
// - enable bit 1: authentication success
// - bit 0 global enable gates line
// - global flag set for enabled source
// - status shows receiver lock flag
module content_protect_status_irq (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       hot_plug_event,
    input  wire logic       receiver_detected,
    input  wire logic       receiver_lock_flag,
    input  wire logic       downstream_irq_n,
    input  wire logic       key_list_loaded,
    input  wire logic       receiver_key_loaded,
    input  wire logic       rx_is_repeater,
    input  wire logic       auth_done,
    input  wire logic       auth_fail,
    input  wire logic       auth_restart,
    input  wire logic       indirect_done,
    input  wire logic       key_list_valid_ack,
    input  wire logic       receiver_key_valid_ack,
    input  wire logic       detect_waits_lock_select,
    output logic            auth_hold,
    output logic            irq_n
);
    typedef struct packed {
        logic [7:0] enables;
        logic [7:0] rdata;
        logic       detect_q;
        logic       rxint_q;
    } top_state_t;

    top_state_t st_r;
    top_state_t st_nxt;

    logic       downstream_hot_plug_flag;
    logic       key_list_ready_flag;
    logic       receiver_key_ready_flag;
    logic       authenticated_flag;
    logic       status_read;
    logic       pending_read;
    logic       enable_write;
    logic       detect_cond;
    logic [7:0] status_value;

    irq_link_if irq_bus ();

    // address decode shared by every access kind
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    assign status_read  = reg_rd & hit(reg_addr, cps_pkg::STATUS_OFS);
    assign pending_read = reg_rd & hit(reg_addr, cps_pkg::PENDING_OFS);
    assign enable_write = reg_wr & hit(reg_addr, cps_pkg::ENABLE_OFS);

    // sticky status flags, each cleared by its own event
    event_flag u_hotplug (
        .clock (clock),
        .sys_rst (sys_rst),
        .set   (hot_plug_event),
        .clr   (status_read),
        .q     (downstream_hot_plug_flag)
    );

    event_flag u_list (
        .clock (clock),
        .sys_rst (sys_rst),
        .set   (key_list_loaded),
        .clr   (key_list_valid_ack),
        .q     (key_list_ready_flag)
    );

    event_flag u_key (
        .clock (clock),
        .sys_rst (sys_rst),
        .set   (receiver_key_loaded),
        .clr   (receiver_key_valid_ack),
        .q     (receiver_key_ready_flag)
    );

    event_flag u_auth (
        .clock (clock),
        .sys_rst (sys_rst),
        .set   (auth_done),
        .clr   (auth_fail | auth_restart),
        .q     (authenticated_flag)
    );

    // hold the engine while a key handshake waits for the controller;
    // a repeater skips the single-key pause and waits on the list instead
    assign auth_hold = key_list_ready_flag
                     | (receiver_key_ready_flag & ~rx_is_repeater);

    // detect condition may wait for lock before it counts
    assign detect_cond = detect_waits_lock_select
                       ? (receiver_detected & receiver_lock_flag)
                       : receiver_detected;

    // event pulses toward the interrupt gate
    assign irq_bus.event_pulse[cps_pkg::IE_INDIRECT] = indirect_done;
    assign irq_bus.event_pulse[cps_pkg::IE_DETECT]   = detect_cond & ~st_r.detect_q;
    assign irq_bus.event_pulse[cps_pkg::IE_RXINT]    = ~downstream_irq_n & st_r.rxint_q;
    assign irq_bus.event_pulse[cps_pkg::IE_LIST]     = key_list_loaded;
    assign irq_bus.event_pulse[cps_pkg::IE_KEY]      = receiver_key_loaded;
    assign irq_bus.event_pulse[cps_pkg::IE_FAIL]     = auth_fail;
    assign irq_bus.event_pulse[cps_pkg::IE_PASS]     = auth_done;

    // enables straight from the register; bit 0 gates the line only
    assign irq_bus.enable        = st_r.enables[7:1];
    assign irq_bus.global_enable = st_r.enables[cps_pkg::IE_GLOBAL];
    assign irq_bus.pending_clear = pending_read;

    irq_combine u_gate (
        .clock   (clock),
        .sys_rst (sys_rst),
        .link    (irq_bus.gate)
    );

    assign irq_n = irq_bus.irq_n;

    // status image; bit 6 is the raw downstream line, active low
    always_comb
    begin
        status_value                     = 8'h00;
        status_value[cps_pkg::ST_RXINT]   = downstream_irq_n;
        status_value[cps_pkg::ST_LOCK]    = receiver_lock_flag;
        status_value[cps_pkg::ST_HOTPLUG] = downstream_hot_plug_flag;
        status_value[cps_pkg::ST_DETECT]  = receiver_detected;
        status_value[cps_pkg::ST_LIST]    = key_list_ready_flag;
        status_value[cps_pkg::ST_KEY]     = receiver_key_ready_flag;
        status_value[cps_pkg::ST_AUTH]    = authenticated_flag;
    end

    // register writes, read data capture and edge history
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.detect_q = detect_cond;
        st_nxt.rxint_q  = downstream_irq_n;
        if (enable_write)
            st_nxt.enables = reg_wdata;
        if (reg_rd)
        begin
            if (hit(reg_addr, cps_pkg::STATUS_OFS))
                st_nxt.rdata = status_value;
            else if (hit(reg_addr, cps_pkg::ENABLE_OFS))
                st_nxt.rdata = st_r.enables;
            else if (hit(reg_addr, cps_pkg::PENDING_OFS))
                st_nxt.rdata = irq_bus.pending_value;
            else
                st_nxt.rdata = cps_pkg::UNMAPPED_VAL;
        end
    end

    // synchronous reset; downstream line idles high so no false edge
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st_r <= '{enables: cps_pkg::ENABLE_RESET, rdata: cps_pkg::RDATA_RESET,
                      detect_q: 1'b0, rxint_q: 1'b1};
        else
            st_r <= st_nxt;
    end

    assign reg_rdata = st_r.rdata;

    enable_reset_a: assert property (@(posedge clock)
        $past(sys_rst) |-> st_r.enables == cps_pkg::ENABLE_RESET)
        else $error("enable register not zero after reset");

    hotplug_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        hot_plug_event ##1 (reg_rd && reg_addr == cps_pkg::STATUS_OFS)
        |=> reg_rdata[cps_pkg::ST_HOTPLUG])
        else $error("hot plug not reported");

    hotplug_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        (status_read && !hot_plug_event) |=> !downstream_hot_plug_flag)
        else $error("hot plug not cleared by read");

    detect_live_a: assert property (@(posedge clock) disable iff (sys_rst)
        status_read |=> reg_rdata[cps_pkg::ST_DETECT] == $past(receiver_detected))
        else $error("detect bit not live");

    list_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
        key_list_loaded |=> (key_list_ready_flag && auth_hold))
        else $error("list ready not held");

    list_ack_a: assert property (@(posedge clock) disable iff (sys_rst)
        (key_list_valid_ack && !key_list_loaded) |=> !key_list_ready_flag)
        else $error("list ready not cleared by acknowledge");

    key_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        receiver_key_loaded |=> receiver_key_ready_flag)
        else $error("key ready not set");

    key_pause_a: assert property (@(posedge clock) disable iff (sys_rst)
        (receiver_key_ready_flag && !rx_is_repeater) |-> auth_hold)
        else $error("no pause on key ready");

    key_ack_a: assert property (@(posedge clock) disable iff (sys_rst)
        (receiver_key_valid_ack && !receiver_key_loaded) |=> !receiver_key_ready_flag)
        else $error("key ready not cleared by acknowledge");

    auth_set_a: assert property (@(posedge clock) disable iff (sys_rst)
        auth_done |=> authenticated_flag)
        else $error("authenticated not set");

    auth_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
        ((auth_fail || auth_restart) && !auth_done) |=> !authenticated_flag)
        else $error("authenticated not cleared");

    detect_wait_a: assert property (@(posedge clock) disable iff (sys_rst)
        (detect_waits_lock_select && !receiver_lock_flag)
        |-> !irq_bus.event_pulse[cps_pkg::IE_DETECT])
        else $error("detect event before lock");

    global_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
        !st_r.enables[cps_pkg::IE_GLOBAL] |=> irq_n)
        else $error("line asserted without global enable");

    pass_line_a: assert property (@(posedge clock) disable iff (sys_rst)
        (auth_done && st_r.enables[cps_pkg::IE_PASS] && st_r.enables[cps_pkg::IE_GLOBAL]
         && !enable_write && !pending_read)
        |=> ##1 !irq_n)
        else $error("success interrupt not raised");

    // writes land whole in the enable register
    enable_write_a: assert property (@(posedge clock) disable iff (sys_rst)
        enable_write |=> st_r.enables == $past(reg_wdata))
        else $error("enable register write lost");

    // status reads show the level flags as they stood at the read
    lock_status_a: assert property (@(posedge clock) disable iff (sys_rst)
        status_read |=> reg_rdata[cps_pkg::ST_LOCK] == $past(receiver_lock_flag))
        else $error("lock bit not shown");

    list_status_a: assert property (@(posedge clock) disable iff (sys_rst)
        status_read |=> reg_rdata[cps_pkg::ST_LIST] == $past(key_list_ready_flag))
        else $error("list ready bit not shown");

    // every source lands in its own pending bit, enabled or not
    indirect_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        indirect_done |=> irq_bus.pending_value[cps_pkg::IE_INDIRECT])
        else $error("indirect event not latched");

    detect_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(detect_cond) |=> irq_bus.pending_value[cps_pkg::IE_DETECT])
        else $error("detect event not latched");

    rxint_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(downstream_irq_n) |=> irq_bus.pending_value[cps_pkg::IE_RXINT])
        else $error("downstream interrupt not latched");

    list_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        key_list_loaded |=> irq_bus.pending_value[cps_pkg::IE_LIST])
        else $error("list ready event not latched");

    key_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        receiver_key_loaded |=> irq_bus.pending_value[cps_pkg::IE_KEY])
        else $error("key ready event not latched");

    fail_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
        auth_fail |=> irq_bus.pending_value[cps_pkg::IE_FAIL])
        else $error("failure event not latched");

    // line low only after the global enable stood on the cycle before
    line_gated_a: assert property (@(posedge clock) disable iff (sys_rst)
        !irq_n |-> $past(st_r.enables[cps_pkg::IE_GLOBAL]))
        else $error("line low without global enable");

    // engine released once no handshake waits on the controller
    hold_release_a: assert property (@(posedge clock) disable iff (sys_rst)
        (!key_list_ready_flag && (!receiver_key_ready_flag || rx_is_repeater)) |-> !auth_hold)
        else $error("engine held with nothing pending");
endmodule

/* File: core/cps_pkg.sv */
/*
 * Shared constants for the content-protection status and interrupt block:
 * register offsets, bit positions and reset values.
 * Assumes an 8-bit serial-control register space behind a simple
 * address/strobe port, all on one clock.
 */
package cps_pkg;
    // register offsets in the serial-control space
    localparam logic [7:0] STATUS_OFS  = 8'hc4;
    localparam logic [7:0] ENABLE_OFS  = 8'hc6;
    localparam logic [7:0] PENDING_OFS = 8'hc7;

    // values after reset, and the value read back from an unmapped address
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] RDATA_RESET  = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

    // status register bit positions
    localparam int ST_RXINT   = 6;
    localparam int ST_LOCK    = 5;
    localparam int ST_HOTPLUG = 4;
    localparam int ST_DETECT  = 3;
    localparam int ST_LIST    = 2;
    localparam int ST_KEY     = 1;
    localparam int ST_AUTH    = 0;

    // interrupt enable / status bit positions
    localparam int IE_INDIRECT = 7;
    localparam int IE_DETECT   = 6;
    localparam int IE_RXINT    = 5;
    localparam int IE_LIST     = 4;
    localparam int IE_KEY      = 3;
    localparam int IE_FAIL     = 2;
    localparam int IE_PASS     = 1;
    localparam int IE_GLOBAL   = 0;
endpackage

/* File: core/event_flag.sv */
/*
 * One sticky status flag: a set pulse raises it, a clear pulse drops it.
 * Assumes set and clear come from logic on the same clock.
 */
`timescale 1ns/1ps
module event_flag (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    typedef struct packed {
        logic q;
    } flag_state_t;

    flag_state_t st_r;
    flag_state_t st_nxt;

    // set beats clear so an event in the clearing cycle survives
    always_comb
    begin
        st_nxt   = st_r;
        st_nxt.q = set | (st_r.q & ~clr);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign q = st_r.q;

    set_wins_a: assert property (@(posedge clock) disable iff (sys_rst)
        set |=> q)
        else $error("flag lost a set pulse");
endmodule

/* File: core/irq_combine.sv */
/*
 * Interrupt gate: latches event pulses into the interrupt status, forms
 * the global flag from the enabled ones and drives the line.
 * Assumes event pulses last one cycle and the clear is a status read.
 */
`timescale 1ns/1ps
module irq_combine (
    input  wire logic   clock,
    input  wire logic   sys_rst,
    irq_link_if.gate    link
);
    typedef struct packed {
        logic [7:1] latched;
        logic       irq_n;
    } gate_state_t;

    gate_state_t st_r;
    gate_state_t st_nxt;
    logic        any_enabled;

    // global flag: any latched source whose enable is set
    assign any_enabled    = |(st_r.latched & link.enable);
    assign link.pending_value = {st_r.latched, any_enabled};
    assign link.irq_n     = st_r.irq_n;

    // latching with set over clear; line held off without global enable
    always_comb
    begin
        st_nxt         = st_r;
        st_nxt.latched = (st_r.latched & ~{7{link.pending_clear}}) | link.event_pulse;
        st_nxt.irq_n   = ~(any_enabled & link.global_enable);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            st_r <= '{latched: 7'h00, irq_n: 1'b1};
        else
            st_r <= st_nxt;
    end

    global_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
        (|(link.event_pulse & link.enable)) ##1 $stable(link.enable)
        |-> link.pending_value[0])
        else $error("global flag missing for an enabled source");
endmodule

/* File: core/irq_link_if.sv */
/*
 * Carrier between the status block and its interrupt gate: event
 * pulses, enables, the status clear and the resulting status and line.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface irq_link_if;
    logic [7:1] event_pulse;
    logic [7:1] enable;
    logic       global_enable;
    logic       pending_clear;
    logic [7:0] pending_value;
    logic       irq_n;

    modport ctrl (output event_pulse, output enable, output global_enable,
                  output pending_clear, input pending_value, input irq_n);
    modport gate (input event_pulse, input enable, input global_enable,
                  input pending_clear, output pending_value, output irq_n);
endinterface

/* File: verif/content_protect_status_irq_test.sv */
/*
 * Self-checking bench for the status flags and interrupt enable block.
 * Assumes downstream_rx_model as far side and one 25 MHz clock.
 */
`timescale 1ns/1ps
module content_protect_status_irq_test;
    logic       clock;
    logic       sys_rst;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       go;
    logic [3:0] cmd;
    logic [2:0] ctl;
    logic       select;
    logic       auth_hold;
    logic       irq_n;
    logic       hp, list_ld, key_ld, done, fail, ind, det, lock, dirq_n, rep;
    int         miscompares = 0;
    int         samples_checked = 0;

    downstream_rx_model partner (.clock(clock), .sys_rst(sys_rst), .go(go), .cmd(cmd),
        .hot_plug_event(hp), .key_list_loaded(list_ld), .receiver_key_loaded(key_ld),
        .auth_done(done), .auth_fail(fail), .indirect_done(ind), .receiver_detected(det),
        .receiver_lock_flag(lock), .downstream_irq_n(dirq_n), .rx_is_repeater(rep));

    content_protect_status_irq DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .hot_plug_event(hp), .receiver_detected(det), .receiver_lock_flag(lock),
        .downstream_irq_n(dirq_n), .key_list_loaded(list_ld), .receiver_key_loaded(key_ld),
        .rx_is_repeater(rep), .auth_done(done), .auth_fail(fail), .auth_restart(ctl[2]),
        .indirect_done(ind), .key_list_valid_ack(ctl[0]), .receiver_key_valid_ack(ctl[1]),
        .detect_waits_lock_select(select), .auth_hold(auth_hold), .irq_n(irq_n));

    task automatic give_verdict();
        if (miscompares == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask

    // data lands on the taking edge, sampled once settled
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1;
        check(reg_rdata, exp);
    endtask

    // model pulse, design latch, then the registered line: three edges
    task automatic ev(input logic [3:0] c);
        @(posedge clock);
        cmd <= c;
        go <= 1'h1;
        @(posedge clock);
        go <= 1'h0;
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic pulse(input int i);
        @(posedge clock);
        ctl[i] <= 1'h1;
        @(posedge clock);
        ctl <= 3'h0;
        @(posedge clock);
        #1;
    endtask

    task automatic reset_values();
        check({7'h0, irq_n}, 8'h01);
        check({7'h0, auth_hold}, 8'h00);
        rd_check(cps_pkg::ENABLE_OFS, 8'h00);
        rd_check(8'h10, 8'h00);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        reg_write(cps_pkg::PENDING_OFS, 8'hff);
        rd_check(cps_pkg::PENDING_OFS, 8'h00);
        reg_write(cps_pkg::ENABLE_OFS, 8'hfe);
        rd_check(cps_pkg::ENABLE_OFS, 8'hfe);
        reg_write(cps_pkg::ENABLE_OFS, 8'h00);
    endtask

    // second hot plug lands on the very edge of a clearing read
    task automatic hot_plug();
        ev(4'h0);
        rd_check(cps_pkg::STATUS_OFS, 8'h50);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        @(posedge clock);
        cmd <= 4'h0;
        go <= 1'h1;
        @(posedge clock);
        go <= 1'h0;
        reg_addr <= cps_pkg::STATUS_OFS;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        rd_check(cps_pkg::STATUS_OFS, 8'h50);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
    endtask

    task automatic levels_and_keys();
        ev(4'h6);
        rd_check(cps_pkg::STATUS_OFS, 8'h48);
        ev(4'h8);
        rd_check(cps_pkg::STATUS_OFS, 8'h68);
        ev(4'h7);
        ev(4'h9);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        ev(4'h1);
        rd_check(cps_pkg::STATUS_OFS, 8'h44);
        check({7'h0, auth_hold}, 8'h01);
        pulse(0); // controller acknowledges the list
        check({7'h0, auth_hold}, 8'h00);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        ev(4'h2);
        rd_check(cps_pkg::STATUS_OFS, 8'h42);
        check({7'h0, auth_hold}, 8'h01);
        pulse(1); // controller acknowledges the key
        check({7'h0, auth_hold}, 8'h00);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        ev(4'hc);
        ev(4'h2);
        check({7'h0, auth_hold}, 8'h00);
        pulse(1);
        ev(4'hd);
        ev(4'h3);
        // protected traffic may start only once this bit reads set
        rd_check(cps_pkg::STATUS_OFS, 8'h41);
        ev(4'h4);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
        ev(4'h3);
        pulse(2);
        rd_check(cps_pkg::STATUS_OFS, 8'h40);
    endtask

    // each source alone, with the global enable on
    task automatic irq_sources();
        logic [3:0] src [1:7];
        src = '{4'h3, 4'h4, 4'h2, 4'h1, 4'ha, 4'h6, 4'h5};
        // detect, list, key, fail and pass were latched earlier with enables off
        rd_check(cps_pkg::PENDING_OFS, 8'h5e);
        for (int b = 1; b < 8; b++)
        begin
            reg_write(cps_pkg::ENABLE_OFS, 8'h01 | (8'h01 << b));
            ev(src[b]);
            check({7'h0, irq_n}, 8'h00);
            rd_check(cps_pkg::PENDING_OFS, 8'h01 | (8'h01 << b));
            @(posedge clock);
            #1;
            check({7'h0, irq_n}, 8'h01);
        end
        ev(4'h7);
        ev(4'hb);
    endtask

    task automatic irq_gating();
        reg_write(cps_pkg::ENABLE_OFS, 8'h02);
        ev(4'h3);
        check({7'h0, irq_n}, 8'h01);
        reg_write(cps_pkg::ENABLE_OFS, 8'h03);
        @(posedge clock);
        #1;
        check({7'h0, irq_n}, 8'h00);
        reg_write(cps_pkg::ENABLE_OFS, 8'h01);
        @(posedge clock);
        #1;
        check({7'h0, irq_n}, 8'h01);
        rd_check(cps_pkg::PENDING_OFS, 8'h02);
    endtask

    task automatic detect_waits_lock();
        @(posedge clock);
        select <= 1'h1;
        reg_write(cps_pkg::ENABLE_OFS, 8'h41);
        ev(4'h6);
        check({7'h0, irq_n}, 8'h01);
        ev(4'h8);
        check({7'h0, irq_n}, 8'h00);
        rd_check(cps_pkg::PENDING_OFS, 8'h41);
        select <= 1'h0;
    endtask

    initial
    begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end

    // a hang is cut short here and reported as broken
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end

    initial
    begin
        sys_rst = 1'h1;
        reg_addr = 8'h00;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_wdata = 8'h00;
        go = 1'h0;
        cmd = 4'h0;
        ctl = 3'h0;
        select = 1'h0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'h0;
        @(posedge clock);
        #1;
        reset_values();
        hot_plug();
        levels_and_keys();
        irq_sources();
        irq_gating();
        detect_waits_lock();
        give_verdict();
    end
endmodule

/* File: verif/downstream_rx_model.sv */
/*
 * Far-side model: cipher engine events and downstream receiver levels.
 * Assumes the bench issues one command per go pulse on the block clock.
 */
`timescale 1ns/1ps
module downstream_rx_model (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       go,
    input  wire logic [3:0] cmd,
    output logic            hot_plug_event,
    output logic            key_list_loaded,
    output logic            receiver_key_loaded,
    output logic            auth_done,
    output logic            auth_fail,
    output logic            indirect_done,
    output logic            receiver_detected,
    output logic            receiver_lock_flag,
    output logic            downstream_irq_n,
    output logic            rx_is_repeater
);
    // single-cycle event pulses, never stretched, as the engine gives them
    always_ff @(posedge clock)
    begin
        hot_plug_event      <= go && cmd == 4'h0;
        key_list_loaded     <= go && cmd == 4'h1;
        receiver_key_loaded <= go && cmd == 4'h2;
        auth_done           <= go && cmd == 4'h3;
        auth_fail           <= go && cmd == 4'h4;
        indirect_done       <= go && cmd == 4'h5;
    end

    // levels hold until a command moves them; line idles released (high)
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            receiver_detected  <= 1'h0;
            receiver_lock_flag <= 1'h0;
            downstream_irq_n   <= 1'h1;
            rx_is_repeater     <= 1'h0;
        end
        else if (go)
        begin
            case (cmd)
                4'h6:    receiver_detected <= 1'h1;
                4'h7:    receiver_detected <= 1'h0;
                4'h8:    receiver_lock_flag <= 1'h1;
                4'h9:    receiver_lock_flag <= 1'h0;
                4'ha:    downstream_irq_n <= 1'h0;
                4'hb:    downstream_irq_n <= 1'h1;
                4'hc:    rx_is_repeater <= 1'h1;
                4'hd:    rx_is_repeater <= 1'h0;
                default: ;
            endcase
        end
    end
endmodule
